// [ebh_pkg.sv]
// Notes on behaviour
// R01 - With the request active and no external access running, the next cycle floats the bus and strobes, asserts grant and halts execution.
// R02 - In run-until-external mode the core keeps running after the grant and stalls only when it needs an external access.
// R03 - A request that arrives during an external access is granted in the cycle after that access completes.
// R04 - The grant may fall inside an instruction, between the first and second of two external accesses.
// R05 - When the request is withdrawn, grant is released, the drivers come back and execution resumes where it stopped.
// R06 - Requests are honoured at all times, including during boot loading and while reset is held.
// R07 - While stalled with the bus given away, grant-hang is asserted whenever the core needs the external bus.
// R08 - Once the bus is released, grant and grant-hang are deasserted and then the pending external access is made.
// R09 - An outside master asserts bus request and leaves the bus alone until grant is asserted.
// R10 - The outside master returns the bus by withdrawing its request, promptly when it sees grant-hang.
// R11 - With emulator enable high, the emulator reset, request and grant pins replace the normal ones and the normal grant floats.
// R12 - The bus request input is passed through a two-stage synchroniser before arbitration acts on it.
`default_nettype none
package ebh_pkg;

   // -----------------------------------------------------------------
   // Arbiter states
   // -----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      EBH_OWN     = 2'b00,
      EBH_GRANTED = 2'b01,
      EBH_RETURN  = 2'b10
   } ebh_state_t;

   // Core-side view of the external bus.
   typedef struct packed
   {
      logic access_busy;
      logic access_need;
      logic access_last;
   } ebh_core_t;

   localparam int SYNC_STAGES = 2;
   localparam logic RESET_STALL = 1'b0;
   localparam logic RESET_GRANT = 1'b0;

endpackage
`default_nettype wire

// [ebh_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module ebh_sync
#(
   parameter int    STAGES = 2,
   parameter logic  INIT   = 1'b1
)
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);

   // A single flop gives metastability no time to settle, so it is refused.
   if (STAGES < 2)
   begin : g_bad_stages
      $error("ebh_sync needs at least two stages.");
   end

   logic [STAGES-1:0] chain_q;

   // -----------------------------------------------------------------
   // Synchroniser chain
   // -----------------------------------------------------------------
   // Only the next stage reads each flop, so metastability settles away from logic.
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         chain_q <= {STAGES{INIT}};
      end
      else
      begin
         chain_q <= {chain_q[STAGES-2:0], din};
      end
   end

   assign dout = chain_q[STAGES-1];

endmodule

`default_nettype wire

// [ebh_arbiter.sv]
`timescale 1ns/1ns
`default_nettype none

module ebh_arbiter
(
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          ext_bus_request_n,
   input  wire logic          emulator_enable,
   input  wire logic          emu_bus_request_n,
   input  wire logic          emu_reset_in_n,
   input  wire logic          run_until_external,
   input  wire ebh_pkg::ebh_core_t core_bus,
   output logic              bus_grant_n,
   output logic              bus_grant_oe,
   output logic              emu_bus_grant_n,
   output logic              grant_hang_n,
   output logic              bus_drive_en,
   output logic              core_stall,
   output logic              core_reset_n
);

   // -----------------------------------------------------------------
   // Request synchronisers
   // -----------------------------------------------------------------
   logic req_norm_n;
   logic req_emu_n;
   logic req_act;

   ebh_sync #(.STAGES(ebh_pkg::SYNC_STAGES), .INIT(1'b1)) u_sync_norm
   (
      .ref_clk (ref_clk),
      .rst_n   (1'b1),
      .din     (ext_bus_request_n),
      .dout    (req_norm_n)
   ); // R12 R06

   ebh_sync #(.STAGES(ebh_pkg::SYNC_STAGES), .INIT(1'b1)) u_sync_emu
   (
      .ref_clk (ref_clk),
      .rst_n   (1'b1),
      .din     (emu_bus_request_n),
      .dout    (req_emu_n)
   ); // R12 R11

   // Emulator enable selects which request pin counts.
   assign req_act = emulator_enable ? !req_emu_n : !req_norm_n; // R11

   // Reset seen by the core comes from the emulator pin in emulation.
   assign core_reset_n = emulator_enable ? emu_reset_in_n : rst_n; // R11

   // -----------------------------------------------------------------
   // Arbitration state
   // -----------------------------------------------------------------
   // Reset only holds the arbiter in EBH_OWN while no request is active, so it keeps
   // granting while rst_n, which also drives the core reset outside emulation, is held.
   ebh_pkg::ebh_state_t state_q;
   logic                stall_q;
   logic                hang_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n && state_q == ebh_pkg::EBH_OWN && !req_act)
      begin
         state_q <= ebh_pkg::EBH_OWN;
      end
      else
      begin
         case (state_q)
            ebh_pkg::EBH_OWN:
            begin
               // Grant only between accesses; a busy access defers it until its last cycle.
               if (req_act && (!core_bus.access_busy || core_bus.access_last))
               begin
                  state_q <= ebh_pkg::EBH_GRANTED; // R01 R03 R04 R06
               end
            end
            ebh_pkg::EBH_GRANTED:
            begin
               if (!req_act)
               begin
                  state_q <= ebh_pkg::EBH_RETURN; // R05 R08
               end
            end
            ebh_pkg::EBH_RETURN:
            begin
               state_q <= ebh_pkg::EBH_OWN;
            end
            default:
            begin
               state_q <= ebh_pkg::EBH_OWN;
            end
         endcase
      end
   end

   // Core stall: halt on grant, or only at an external access in run-until-external.
   always_ff @(posedge ref_clk)
   begin
      if (state_q == ebh_pkg::EBH_GRANTED && req_act)
      begin
         stall_q <= !run_until_external || core_bus.access_need; // R01 R02
      end
      else
      begin
         stall_q <= ebh_pkg::RESET_STALL; // R05
      end
   end

   // Grant-hang while the core waits on the bus it gave away.
   always_ff @(posedge ref_clk)
   begin
      hang_q <= state_q == ebh_pkg::EBH_GRANTED && req_act && core_bus.access_need; // R07 R08
   end

   // -----------------------------------------------------------------
   // Pin drive
   // -----------------------------------------------------------------
   logic granted;
   assign granted        = state_q == ebh_pkg::EBH_GRANTED;
   assign bus_drive_en   = !granted;                              // R01 R05
   assign bus_grant_n    = !(granted && !emulator_enable);
   assign bus_grant_oe   = !emulator_enable;                      // R11
   assign emu_bus_grant_n = !(granted && emulator_enable);        // R11
   assign grant_hang_n   = !hang_q;                               // R07 R08
   assign core_stall     = stall_q || (granted && !run_until_external); // R01 R02

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   // A request that meets no external access in flight.
   sequence s_req_free;
      state_q == ebh_pkg::EBH_OWN && req_act && !core_bus.access_busy;
   endsequence

   // A request that meets the last cycle of an access.
   sequence s_req_split;
      state_q == ebh_pkg::EBH_OWN && req_act
         && core_bus.access_busy && core_bus.access_last;
   endsequence

   // A request that meets an access still under way.
   sequence s_req_busy;
      state_q == ebh_pkg::EBH_OWN && req_act
         && core_bus.access_busy && !core_bus.access_last;
   endsequence

   // The outside master has withdrawn its request.
   sequence s_release;
      state_q == ebh_pkg::EBH_GRANTED && !req_act;
   endsequence

   // One return cycle with the drivers back, then the core owns the bus.
   sequence s_handback;
      state_q == ebh_pkg::EBH_RETURN && bus_drive_en && !core_stall
         ##1 state_q == ebh_pkg::EBH_OWN;
   endsequence

   // A free bus is handed over on the next edge with the drivers off.
   property p_grant_idle;
      @(posedge ref_clk) disable iff (!rst_n)
      s_req_free |=> granted && !bus_drive_en;
   endproperty

   grant_when_idle_a: assert property (p_grant_idle) // R01
   else
   begin
      $error("Idle bus was not granted on the next edge.");
   end

   // The grant may fall between two accesses of one instruction.
   property p_grant_split;
      @(posedge ref_clk) disable iff (!rst_n)
      s_req_split |=> granted;
   endproperty

   grant_between_access_a: assert property (p_grant_split) // R04
   else
   begin
      $error("Grant was not given after the last access cycle.");
   end

   // A running access defers the grant.
   property p_busy_defer;
      @(posedge ref_clk) disable iff (!rst_n)
      s_req_busy |=> !granted;
   endproperty

   busy_defers_grant_a: assert property (p_busy_defer) // R03
   else
   begin
      $error("Grant was given during an external access.");
   end

   // In normal mode a grant halts the core and floats the bus.
   property p_halt;
      @(posedge ref_clk) disable iff (!rst_n)
      granted && !run_until_external |-> core_stall && !bus_drive_en;
   endproperty

   halt_on_grant_a: assert property (p_halt) // R01
   else
   begin
      $error("Core was not halted with the bus granted.");
   end

   // In run-until-external mode the core keeps going without a bus need.
   property p_run_on;
      @(posedge ref_clk) disable iff (!rst_n)
      (granted && req_act && run_until_external && !core_bus.access_need)
         ##1 (granted && run_until_external) |-> !core_stall;
   endproperty

   run_until_need_a: assert property (p_run_on) // R02
   else
   begin
      $error("Core stalled without needing the external bus.");
   end

   // Withdrawing the request restores the drivers and resumes the core.
   property p_release;
      @(posedge ref_clk) disable iff (!rst_n)
      s_release |=> s_handback;
   endproperty

   release_resumes_a: assert property (p_release) // R05
   else
   begin
      $error("Bus was not handed back after the request was withdrawn.");
   end

   // Grant-hang only follows a core need while the bus is away.
   property p_hang_cause;
      @(posedge ref_clk) disable iff (!rst_n)
      !grant_hang_n |-> $past(granted && core_bus.access_need);
   endproperty

   hang_needs_grant_a: assert property (p_hang_cause) // R07
   else
   begin
      $error("Grant-hang asserted without a pending core access.");
   end

   // Release clears grant and grant-hang together.
   property p_hang_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      s_release |=> grant_hang_n && bus_grant_n && emu_bus_grant_n;
   endproperty

   release_clears_hang_a: assert property (p_hang_clear) // R08
   else
   begin
      $error("Grant or grant-hang stayed asserted after release.");
   end

   // The normal grant floats while the emulator owns the pins.
   property p_emu_float;
      @(posedge ref_clk) disable iff (!rst_n)
      emulator_enable |-> !bus_grant_oe && bus_grant_n;
   endproperty

   emu_grant_float_a: assert property (p_emu_float) // R11
   else
   begin
      $error("Normal grant was driven in emulation.");
   end

   // Reset does not stop a request from being granted.
   property p_reset_grant;
      @(posedge ref_clk)
      (!rst_n && state_q == ebh_pkg::EBH_OWN && req_act && !core_bus.access_busy)
         |=> granted;
   endproperty

   grant_under_reset_a: assert property (p_reset_grant) // R06
   else
   begin
      $error("Request was not granted while reset was held.");
   end

endmodule

`default_nettype wire

// [ebh_master.sv]
`timescale 1ns/1ns
`default_nettype none

module ebh_master
(
   input  wire logic ref_clk,
   input  wire logic want,
   input  wire logic bus_grant_n,
   input  wire logic grant_hang_n,
   output logic      ext_bus_request_n = 1'b1,
   output logic      master_drive
);
   // Requests while wanted and gives the bus back at once on grant-hang.
   always @(posedge ref_clk)
   begin
      ext_bus_request_n <= !(want && grant_hang_n);
   end

   // Drives the shared bus only while it is granted.
   assign master_drive = !ext_bus_request_n && !bus_grant_n;
endmodule

`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ns
`default_nettype none

module testbench;
   logic               ref_clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               want = 1'b0;
   logic               emu_en = 1'b0;
   logic               emu_req_n = 1'b1;
   logic               emu_rst_n = 1'b1;
   logic               run = 1'b0;
   ebh_pkg::ebh_core_t cb = '0;
   logic               req_n, gnt_n, goe, egnt_n, hang_n, drv, stall, crst_n, mdrv;
   int                 errors = 0;
   int                 tests_run = 0;

   ebh_arbiter DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ext_bus_request_n(req_n),
      .emulator_enable(emu_en), .emu_bus_request_n(emu_req_n), .emu_reset_in_n(emu_rst_n),
      .run_until_external(run), .core_bus(cb), .bus_grant_n(gnt_n), .bus_grant_oe(goe),
      .emu_bus_grant_n(egnt_n), .grant_hang_n(hang_n), .bus_drive_en(drv),
      .core_stall(stall), .core_reset_n(crst_n));
   ebh_master partner (.ref_clk(ref_clk), .want(want), .bus_grant_n(gnt_n),
      .grant_hang_n(hang_n), .ext_bus_request_n(req_n), .master_drive(mdrv));

   // Free-running processor clock.
   always #5 ref_clk = ~ref_clk;

   // Counts one comparison and reports a difference.
   task automatic chk(input logic got, input logic exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %b expected %b", $time, got, exp);
      end
   endtask

   // Grant is held off only by an access that is not in its last cycle.
   function automatic logic exp_grant_n(input logic busy, input logic last);
      return busy && !last;
   endfunction

   // The core halts on a grant unless it runs on until an external access.
   function automatic logic exp_stall(input logic run_on);
      return !run_on;
   endfunction

   // Picks a watched output by number.
   function automatic logic sig(input int s);
      return (s == 0) ? gnt_n : (s == 1) ? hang_n : egnt_n;
   endfunction

   // Waits a bounded number of edges for an output level, then compares.
   task automatic wt(input int s, input logic e);
      int n;
      n = 0;
      while (sig(s) !== e && n < 12)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk(sig(s), e);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
      begin
         $display("All tests passed");
      end
      else
      begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Main sequence: random handovers, then reset and emulator cases.
   initial
   begin
      void'($urandom(84));
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         // The first two rounds force a busy access; the first also forces its last cycle, a split access.
         cb.access_busy <= (i < 2) ? 1'b1 : 1'($urandom);
         cb.access_last <= (i == 0) ? 1'b1 : 1'($urandom);
         run <= 1'($urandom);
         want <= 1'b1;
         repeat (6) @(posedge ref_clk);
         chk(goe, 1'b1);
         chk(crst_n, 1'b1);
         if (cb.access_busy)
         begin
            chk(gnt_n, exp_grant_n(cb.access_busy, cb.access_last));
            cb.access_busy <= 1'b0;
            cb.access_last <= 1'b0;
         end
         wt(0, 1'b0);
         chk(drv, 1'b0);
         chk(mdrv, 1'b1);
         chk(stall, exp_stall(run));
         if (i[0])
         begin
            cb.access_need <= 1'b1;
            wt(1, 1'b0);
            want <= 1'b0;
            wt(0, 1'b1);
            wt(1, 1'b1);
            cb.access_need <= 1'b0;
         end
         else
         begin
            want <= 1'b0;
            wt(0, 1'b1);
         end
         repeat (3) @(posedge ref_clk);
         chk(drv, 1'b1);
         chk(stall, 1'b0);
         $display("test %0d done", i);
      end
      rst_n <= 1'b0;
      want <= 1'b1;
      wt(0, 1'b0);
      want <= 1'b0;
      wt(0, 1'b1);
      $display("test reset done");
      rst_n <= 1'b1;
      emu_en <= 1'b1;
      emu_req_n <= 1'b0;
      emu_rst_n <= 1'b0;
      wt(2, 1'b0);
      chk(goe, 1'b0);
      chk(crst_n, 1'b0);
      chk(gnt_n, 1'b1);
      $display("test emulator done");
      end_of_test();
   end

   // Watchdog that cuts a hang short; the tests need some 130 cycles, this allows 2000.
   initial
   begin
      #20000;
      errors++;
      end_of_test();
   end
endmodule

`default_nettype wire
